/* rtl/mia_arbiter.sv */
// interrupt arbiter: pending flags, masks, two-level priority, vectors
`timescale 1ns/1ns
module mia_arbiter (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic EXTERNAL_IRQ_ZERO_INPUT_N,
    input wire logic EXTERNAL_IRQ_ONE_INPUT_N,
    input wire logic TIMER_ZERO_OVERFLOW_FLAG,
    input wire logic TIMER_ONE_OVERFLOW_FLAG,
    input wire logic [3:0] HELD_FLAG_SET,
    input wire logic [3:0] HELD_FLAG_CLR,
    output logic [3:0] HELD_FLAGS,
    input wire mia_pkg::mia_periph_s PERIPH_FLAGS,
    input wire logic [7:0] EXTENDED_MASK,
    input wire logic [14:0] SRC_PRIO_HIGH,
    input wire logic CPU_INSTR_DONE,
    input wire logic CPU_RETURN_FROM_SERVICE_OP_DONE,
    input wire logic CPU_VECTOR_TAKE,
    output logic IRQ_REQ,
    output logic [15:0] IRQ_VECTOR,
    output logic IRQ_HIGH,
    output logic [1:0] INSERV_LEVEL
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // lowest set bit wins within one level
    function automatic mia_pkg::mia_pick_s pick_lowest(
        input logic [14:0] req
    );
        mia_pkg::mia_pick_s p;
        p.found = 1'b0;
        p.idx = mia_pkg::MIA_IDX_RESET;
        for (int i = mia_pkg::MIA_NUM_SRC - 1; i >= 0; i--) begin
            if (req[i]) begin
                p.found = 1'b1;
                p.idx = 4'(i);
            end
        end
        return p;
    endfunction : pick_lowest

    // vector = base plus eight bytes per order number
    function automatic logic [15:0] vector_of(input logic [3:0] idx);
        return mia_pkg::MIA_VECTOR_BASE + {9'h000, idx, 3'h0};
    endfunction : vector_of

    // one decode shared by write and read so both always agree
    function automatic logic is_mask_addr(input logic [7:0] addr);
        return addr == mia_pkg::MIA_IRQ_ENABLE_MASK_ADDR;
    endfunction : is_mask_addr

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [7:0] irq_enable_mask;
    logic ext0_meta, ext0_sync, ext0_prev;
    logic ext1_meta, ext1_sync, ext1_prev;
    logic [3:0] held_set, take_clr;
    logic [14:0] pend, gate, eligible;
    mia_pkg::mia_pick_s pick_hi, pick_lo;
    logic win_valid, win_high;
    logic [3:0] win_idx;
    logic inserv_hi, inserv_lo;
    logic return_from_service_op_hold;
    logic level_ok;

    // ------------------------------------------------------------------
    // register access
    // ------------------------------------------------------------------
    // enable mask, written at its own address only
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            irq_enable_mask <= mia_pkg::MIA_IRQ_ENABLE_MASK_RESET;
        end else if (SFR_WR && is_mask_addr(SFR_ADDR)) begin
            irq_enable_mask <= SFR_WDATA;
        end
    end

    // read data one clock after the strobe; other addresses read zero
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            SFR_RDATA <= mia_pkg::MIA_RDATA_RESET;
        end else if (SFR_RD && is_mask_addr(SFR_ADDR)) begin
            SFR_RDATA <= irq_enable_mask;
        end else begin
            SFR_RDATA <= mia_pkg::MIA_RDATA_RESET;
        end
    end

    // ------------------------------------------------------------------
    // external pins and hardware-cleared flags
    // ------------------------------------------------------------------
    // pins are asynchronous: two stages, edge seen only after stage two
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ext0_meta <= 1'b1;
            ext0_sync <= 1'b1;
            ext0_prev <= 1'b1;
            ext1_meta <= 1'b1;
            ext1_sync <= 1'b1;
            ext1_prev <= 1'b1;
        end else begin
            ext0_meta <= EXTERNAL_IRQ_ZERO_INPUT_N;
            ext0_sync <= ext0_meta;
            ext0_prev <= ext0_sync;
            ext1_meta <= EXTERNAL_IRQ_ONE_INPUT_N;
            ext1_sync <= ext1_meta;
            ext1_prev <= ext1_sync;
        end
    end

    // falling pin edge, overflow pulse or software write sets a flag
    always_comb begin
        held_set = HELD_FLAG_SET;
        held_set[mia_pkg::MIA_SRC_EXT_ZERO] |= ext0_prev & ~ext0_sync;
        held_set[mia_pkg::MIA_SRC_TIMER_ZERO] |= TIMER_ZERO_OVERFLOW_FLAG;
        held_set[mia_pkg::MIA_SRC_EXT_ONE] |= ext1_prev & ~ext1_sync;
        held_set[mia_pkg::MIA_SRC_TIMER_ONE] |= TIMER_ONE_OVERFLOW_FLAG;
        take_clr = 4'h0;
        if (CPU_VECTOR_TAKE && win_idx < 4'(mia_pkg::MIA_NUM_HELD)) begin
            take_clr[win_idx[1:0]] = 1'b1;
        end
    end

    // set beats clear in the same clock so no event is lost
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            HELD_FLAGS <= 4'h0;
        end else begin
            HELD_FLAGS <= (HELD_FLAGS & ~(HELD_FLAG_CLR | take_clr))
                | held_set;
        end
    end

    // ------------------------------------------------------------------
    // masking and arbitration
    // ------------------------------------------------------------------
    // pending collected unmasked; masks act on the request only
    always_comb begin
        pend = 15'h0000;
        pend[3:0] = HELD_FLAGS;
        pend[mia_pkg::MIA_SRC_ASYNC_SERIAL] = PERIPH_FLAGS.uart_rx_done
            | PERIPH_FLAGS.uart_tx_done;
        pend[mia_pkg::MIA_SRC_TIMER_TWO] =
            PERIPH_FLAGS.timer_two_low_overflow_flag
            | PERIPH_FLAGS.timer_two_high_overflow_flag;
        pend[mia_pkg::MIA_SRC_SERIAL_PERIPH] = |PERIPH_FLAGS.spi_flags;
        pend[14:7] = PERIPH_FLAGS.extended_flags;
        pend[mia_pkg::MIA_SRC_RESERVED] = 1'b0;
    end

    // per-source gate, all of it under the global gate
    always_comb begin
        gate = 15'h0000;
        gate[mia_pkg::MIA_SRC_EXT_ZERO] =
            irq_enable_mask[mia_pkg::MIA_EXTERNAL_ZERO_BIT];
        gate[mia_pkg::MIA_SRC_TIMER_ZERO] =
            irq_enable_mask[mia_pkg::MIA_TIMER_ZERO_BIT];
        gate[mia_pkg::MIA_SRC_EXT_ONE] =
            irq_enable_mask[mia_pkg::MIA_EXTERNAL_ONE_BIT];
        gate[mia_pkg::MIA_SRC_TIMER_ONE] =
            irq_enable_mask[mia_pkg::MIA_TIMER_ONE_BIT];
        gate[mia_pkg::MIA_SRC_ASYNC_SERIAL] =
            irq_enable_mask[mia_pkg::MIA_ASYNC_SERIAL_BIT];
        gate[mia_pkg::MIA_SRC_TIMER_TWO] =
            irq_enable_mask[mia_pkg::MIA_TIMER_TWO_BIT];
        gate[mia_pkg::MIA_SRC_SERIAL_PERIPH] =
            irq_enable_mask[mia_pkg::MIA_SERIAL_PERIPH_BIT];
        gate[14:7] = EXTENDED_MASK;
        eligible = pend & gate
            & {15{irq_enable_mask[mia_pkg::MIA_GLOBAL_GATE_BIT]}};
        pick_hi = pick_lowest(eligible & SRC_PRIO_HIGH);
        pick_lo = pick_lowest(eligible & ~SRC_PRIO_HIGH);
    end

    // winner registered each clock: one clock of detection
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            win_valid <= 1'b0;
            win_high <= 1'b0;
            win_idx <= mia_pkg::MIA_IDX_RESET;
            IRQ_VECTOR <= mia_pkg::MIA_RESET_VECTOR;
        end else if (pick_hi.found) begin
            win_valid <= 1'b1;
            win_high <= 1'b1;
            win_idx <= pick_hi.idx;
            IRQ_VECTOR <= vector_of(pick_hi.idx);
        end else begin
            win_valid <= pick_lo.found;
            win_high <= 1'b0;
            win_idx <= pick_lo.idx;
            IRQ_VECTOR <= pick_lo.found ? vector_of(pick_lo.idx)
                : IRQ_VECTOR;
        end
    end

    // ------------------------------------------------------------------
    // service state
    // ------------------------------------------------------------------
    // in-service levels; a return retires the higher active level first
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            inserv_hi <= 1'b0;
            inserv_lo <= 1'b0;
        end else begin
            if (CPU_VECTOR_TAKE && win_high) begin
                inserv_hi <= 1'b1;
            end else if (CPU_RETURN_FROM_SERVICE_OP_DONE && inserv_hi) begin
                inserv_hi <= 1'b0;
            end
            if (CPU_VECTOR_TAKE && !win_high) begin
                inserv_lo <= 1'b1;
            end else if (CPU_RETURN_FROM_SERVICE_OP_DONE && !inserv_hi) begin
                inserv_lo <= 1'b0;
            end
        end
    end

    // after a return, hold requests until one more instruction completes
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            return_from_service_op_hold <= 1'b0;
        end else if (CPU_RETURN_FROM_SERVICE_OP_DONE) begin
            return_from_service_op_hold <= 1'b1;
        end else if (CPU_INSTR_DONE) begin
            return_from_service_op_hold <= 1'b0;
        end
    end

    // high may preempt low; equal or higher handler blocks
    always_comb begin
        level_ok = win_high ? !inserv_hi
            : (!inserv_hi && !inserv_lo);
    end

    // request is combinational so the cpu sees it the clock after detect;
    // call and return timing belong to the sequencer
    assign IRQ_REQ = win_valid && level_ok && !return_from_service_op_hold;
    assign IRQ_HIGH = win_high;
    assign INSERV_LEVEL = {inserv_hi, inserv_lo};

endmodule : mia_arbiter

/* pkg/mia_pkg.sv */
// shared constants and carrier types of the interrupt arbiter
package mia_pkg;

    // ------------------------------------------------------------------
    // register map and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] MIA_IRQ_ENABLE_MASK_ADDR = 8'hA8;
    localparam logic [7:0] MIA_IRQ_ENABLE_MASK_RESET = 8'h00;
    localparam logic [7:0] MIA_RDATA_RESET = 8'h00;
    localparam int unsigned MIA_GLOBAL_GATE_BIT = 7;
    localparam int unsigned MIA_SERIAL_PERIPH_BIT = 6;
    localparam int unsigned MIA_TIMER_TWO_BIT = 5;
    localparam int unsigned MIA_ASYNC_SERIAL_BIT = 4;
    localparam int unsigned MIA_TIMER_ONE_BIT = 3;
    localparam int unsigned MIA_EXTERNAL_ONE_BIT = 2;
    localparam int unsigned MIA_TIMER_ZERO_BIT = 1;
    localparam int unsigned MIA_EXTERNAL_ZERO_BIT = 0;

    // ------------------------------------------------------------------
    // sources, order numbers and vectors
    // ------------------------------------------------------------------
    localparam int unsigned MIA_NUM_SRC = 15;
    localparam int unsigned MIA_NUM_HELD = 4;
    localparam int unsigned MIA_SRC_EXT_ZERO = 0;
    localparam int unsigned MIA_SRC_TIMER_ZERO = 1;
    localparam int unsigned MIA_SRC_EXT_ONE = 2;
    localparam int unsigned MIA_SRC_TIMER_ONE = 3;
    localparam int unsigned MIA_SRC_ASYNC_SERIAL = 4;
    localparam int unsigned MIA_SRC_TIMER_TWO = 5;
    localparam int unsigned MIA_SRC_SERIAL_PERIPH = 6;
    localparam int unsigned MIA_SRC_FIRST_EXTENDED = 7;
    localparam int unsigned MIA_SRC_RESERVED = 8;
    localparam logic [15:0] MIA_RESET_VECTOR = 16'h0000;
    localparam logic [15:0] MIA_VECTOR_BASE = 16'h0003;
    localparam logic [15:0] MIA_VECTOR_LAST = 16'h0073;
    localparam logic [15:0] MIA_VECTOR_RESERVED = 16'h0043;
    localparam logic [3:0] MIA_IDX_RESET = 4'h0;

    // ------------------------------------------------------------------
    // response timing in system clocks (cpu side carries the call)
    // ------------------------------------------------------------------
    localparam int unsigned MIA_DETECT_CYCLES = 1;
    localparam int unsigned MIA_CALL_CYCLES = 4;
    localparam int unsigned MIA_MIN_LATENCY = 5;
    localparam int unsigned MIA_RETURN_CYCLES = 5;
    localparam int unsigned MIA_DIVIDE_CYCLES = 8;
    localparam int unsigned MIA_MAX_LATENCY = 18;

    // level flags kept inside the peripherals, cleared by software there
    typedef struct packed {
        logic uart_rx_done;
        logic uart_tx_done;
        logic timer_two_low_overflow_flag;
        logic timer_two_high_overflow_flag;
        logic [3:0] spi_flags;
        logic [7:0] extended_flags; // order 7..14, bit 1 is the gap
    } mia_periph_s;

    // winner of one arbitration pass
    typedef struct packed {
        logic found;
        logic [3:0] idx;
    } mia_pick_s;

endpackage : mia_pkg

/* tb/mia_cpu_model.sv */
// cpu sequencer stand-in: takes requests, then spends the call clocks
`timescale 1ns/1ns
module mia_cpu_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic irq_req,
    input wire logic take_en,
    output logic vector_take
);
    logic [2:0] busy;
    // take only while the request stands and no call is under way
    assign vector_take = irq_req && take_en && busy == 3'h0;
    // four clocks of long call after each take; no take meanwhile
    always_ff @(posedge core_clk) begin
        if (srst) begin
            busy <= 3'h0;
        end else if (vector_take) begin
            busy <= 3'h4;
        end else if (busy != 3'h0) begin
            busy <= busy - 3'h1;
        end
    end
endmodule : mia_cpu_model

/* tb/mia_arbiter_checker.sv */
// port checker for the interrupt arbiter, bound to the design
`timescale 1ns/1ns
module mia_arbiter_checker (
    input wire logic CORE_CLK,
    input wire logic SRST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    input wire logic [3:0] HELD_FLAGS,
    input wire logic TIMER_ZERO_OVERFLOW_FLAG,
    input wire logic [3:0] HELD_FLAG_SET,
    input wire logic CPU_INSTR_DONE,
    input wire logic CPU_RETURN_FROM_SERVICE_OP_DONE,
    input wire logic CPU_VECTOR_TAKE,
    input wire logic IRQ_REQ,
    input wire logic [15:0] IRQ_VECTOR,
    input wire logic IRQ_HIGH,
    input wire logic [1:0] INSERV_LEVEL
);
    localparam logic [7:0] A = mia_pkg::MIA_IRQ_ENABLE_MASK_ADDR;
    logic gate;
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (SRST);
    // ------------------------------------------------------------------
    // shadow of the global gate, fed by mask writes
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            gate <= 1'b0;
        end else if (SFR_WR && SFR_ADDR == A) begin
            gate <= SFR_WDATA[mia_pkg::MIA_GLOBAL_GATE_BIT];
        end
    end
    // write then read back at once; return then two idle clocks
    sequence s_wr_rd;
        SFR_WR && SFR_ADDR == A ##1 SFR_RD && SFR_ADDR == A;
    endsequence
    sequence s_ret_wait;
        CPU_RETURN_FROM_SERVICE_OP_DONE ##1 !CPU_INSTR_DONE [*2];
    endsequence
    chk_rd_idle: assert property (
        (!SFR_RD || SFR_ADDR != A) |=> SFR_RDATA == 8'h00)
        else $error("read data not zero outside a mask read");
    chk_wr_rd: assert property (
        s_wr_rd |=> SFR_RDATA == $past(SFR_WDATA, 2))
        else $error("mask read back differs from write");
    chk_gate_off: assert property (
        !gate && !$past(gate) |-> !IRQ_REQ)
        else $error("request with global gate clear");
    chk_vec_legal: assert property (
        IRQ_REQ |-> IRQ_VECTOR[2:0] == 3'h3 && IRQ_VECTOR <= 16'h0073
            && IRQ_VECTOR != 16'h0043)
        else $error("illegal vector offered");
    chk_high_block: assert property (
        INSERV_LEVEL[1] |-> !IRQ_REQ)
        else $error("request while high handler runs");
    chk_low_block: assert property (
        INSERV_LEVEL[0] && !IRQ_HIGH |-> !IRQ_REQ)
        else $error("low request while handler runs");
    chk_return_from_service_op_hold: assert property (
        s_ret_wait |-> !IRQ_REQ)
        else $error("request before one instruction after return");
    chk_take_clear: assert property (
        CPU_VECTOR_TAKE && IRQ_VECTOR == 16'h000B && !HELD_FLAG_SET[1]
            && !TIMER_ZERO_OVERFLOW_FLAG |=> !HELD_FLAGS[1])
        else $error("timer zero flag kept after vectoring");
    chk_take_level: assert property (
        CPU_VECTOR_TAKE |=> (INSERV_LEVEL
            & {$past(IRQ_HIGH), !$past(IRQ_HIGH)}) != 2'b00)
        else $error("in-service level not set on take");
endmodule : mia_arbiter_checker
bind mia_arbiter mia_arbiter_checker u_chk (.CORE_CLK(CORE_CLK),
    .SRST(SRST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR),
    .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA),
    .HELD_FLAGS(HELD_FLAGS), .HELD_FLAG_SET(HELD_FLAG_SET),
    .TIMER_ZERO_OVERFLOW_FLAG(TIMER_ZERO_OVERFLOW_FLAG),
    .CPU_INSTR_DONE(CPU_INSTR_DONE), .CPU_RETURN_FROM_SERVICE_OP_DONE(CPU_RETURN_FROM_SERVICE_OP_DONE),
    .CPU_VECTOR_TAKE(CPU_VECTOR_TAKE), .IRQ_REQ(IRQ_REQ),
    .IRQ_VECTOR(IRQ_VECTOR), .IRQ_HIGH(IRQ_HIGH),
    .INSERV_LEVEL(INSERV_LEVEL));

/* tb/mia_arbiter_tb_top.sv */
// self-checking bench for the interrupt arbiter
`timescale 1ns/1ns
module mia_arbiter_tb_top;
    localparam logic [7:0] A = mia_pkg::MIA_IRQ_ENABLE_MASK_ADDR;
    logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, t0 = 1'b0;
    logic ext0_n = 1'b1, instr = 1'b0, return_from_service_op = 1'b0, take_en = 1'b0;
    logic ext1_n = 1'b1, t1 = 1'b0;
    logic take, req, high;
    logic [7:0] addr = 8'h00, wdata = 8'h00, emask = 8'h00, rdata, rv;
    logic [3:0] hset = 4'h0, hclr = 4'h0, held;
    logic [14:0] prio = 15'h0000;
    logic [15:0] vec;
    logic [1:0] insv;
    mia_pkg::mia_periph_s pf = '0;
    int n_fail = 0, n_tests = 0, cycles = 0;
    always #2 clk = ~clk;
    mia_arbiter u_dut (.CORE_CLK(clk), .SRST(srst), .SFR_ADDR(addr),
        .SFR_WR(wr), .SFR_WDATA(wdata), .SFR_RD(rd), .SFR_RDATA(rdata),
        .EXTERNAL_IRQ_ZERO_INPUT_N(ext0_n), .EXTERNAL_IRQ_ONE_INPUT_N(ext1_n),
        .TIMER_ZERO_OVERFLOW_FLAG(t0), .TIMER_ONE_OVERFLOW_FLAG(t1),
        .HELD_FLAG_SET(hset), .HELD_FLAG_CLR(hclr), .HELD_FLAGS(held),
        .PERIPH_FLAGS(pf), .EXTENDED_MASK(emask), .SRC_PRIO_HIGH(prio),
        .CPU_INSTR_DONE(instr), .CPU_RETURN_FROM_SERVICE_OP_DONE(return_from_service_op),
        .CPU_VECTOR_TAKE(take), .IRQ_REQ(req), .IRQ_VECTOR(vec),
        .IRQ_HIGH(high), .INSERV_LEVEL(insv));
    mia_cpu_model u_cpu (.core_clk(clk), .srst(srst), .irq_req(req),
        .take_en(take_en), .vector_take(take));
    // ------------------------------------------------------------------
    // access tasks, all changes at the falling edge
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        cyc(1);
        d = rdata;
        rd = 1'b0;
    endtask : rd_reg
    task automatic pulse_return_from_service_op();
        return_from_service_op = 1'b1;
        cyc(1);
        return_from_service_op = 1'b0;
    endtask : pulse_return_from_service_op
    // lets the cpu take once; the call keeps it from a second take
    task automatic grab();
        take_en = 1'b1;
        cyc(5);
        take_en = 1'b0;
    endtask : grab
    // raise or drop the pending condition of source order b
    task automatic src(input int b, input logic v);
        if (b < 4) begin
            hset[b] = v;
            hclr[b] = !v;
            cyc(1);
            hset = 4'h0;
            hclr = 4'h0;
        end else if (b == 4) pf.uart_tx_done = v;
        else if (b == 5) pf.timer_two_high_overflow_flag = v;
        else pf.spi_flags[3] = v;
        cyc(1); // idle clock so a following call never rewrites in one step
    endtask : src
    task automatic do_reset();
        srst = 1'b1;
        cyc(20);
        srst = 1'b0;
        chk(vec, 16'h0000);
        chk(16'({held, insv, req}), 16'h0000);
        rd_reg(A, rv);
        chk(16'(rv), 16'h0000);
    endtask : do_reset
    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // hang guard, well above the roughly 190 clocks of the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            print_verdict();
        end
    end
    // main sequence
    initial begin
        do_reset();
        ext0_n = 1'b0;
        ext1_n = 1'b0;
        t1 = 1'b1;
        cyc(1);
        t1 = 1'b0;
        cyc(4);
        chk(16'(held), 16'h000D);
        ext0_n = 1'b1;
        ext1_n = 1'b1;
        src(0, 1'b0);
        src(2, 1'b0);
        src(3, 1'b0);
        chk(16'(held), 16'h0000);
        wr_reg(8'hA9, 8'hFF);
        cyc(1);
        wr_reg(A, 8'h82);
        rd_reg(A, rv);
        chk(16'(rv), 16'h0082);
        cyc(1);
        rd_reg(8'hB8, rv);
        chk(16'(rv), 16'h0000);
        take_en = 1'b1;
        t0 = 1'b1;
        cyc(1);
        t0 = 1'b0;
        cyc(1);
        chk(vec, 16'h000B);
        chk(16'(req), 16'h0001);
        cyc(1);
        take_en = 1'b0;
        chk(16'({held[1], insv, req}), 16'h0002);
        wr_reg(A, 8'h90);
        pf.uart_rx_done = 1'b1;
        cyc(2);
        chk(16'(req), 16'h0000);
        pulse_return_from_service_op();
        chk(16'({insv, req}), 16'h0000);
        cyc(3);
        chk(16'(req), 16'h0000);
        instr = 1'b1;
        cyc(1);
        instr = 1'b0;
        chk(vec, 16'h0023);
        chk(16'(req), 16'h0001);
        pf.uart_rx_done = 1'b0;
        for (int b = 0; b < 7; b++) begin
            wr_reg(A, 8'h7F);
            src(b, 1'b1);
            cyc(2);
            chk(16'(req), 16'h0000);
            wr_reg(A, 8'h80 | (8'h01 << b));
            cyc(2);
            chk(vec, 16'h0003 + 16'(b) * 16'h0008);
            chk(16'(req), 16'h0001);
            wr_reg(A, 8'hFF ^ (8'h01 << b));
            cyc(2);
            chk(16'(req), 16'h0000);
            src(b, 1'b0);
        end
        for (int b = 0; b < 7; b++) src(b, 1'b1);
        pf.extended_flags = 8'h82;
        emask = 8'hFF;
        wr_reg(A, 8'hFF);
        cyc(2);
        chk(vec, 16'h0003);
        wr_reg(A, 8'h80);
        cyc(2);
        chk(vec, 16'h0073);
        pf.extended_flags = 8'h00;
        wr_reg(A, 8'h9C);
        cyc(2);
        chk(vec, 16'h0013);
        grab();
        prio = 15'h0008;
        cyc(2);
        chk(16'({high, req}), 16'h0003);
        chk(vec, 16'h001B);
        grab();
        prio = 15'h0018;
        cyc(2);
        chk(16'({insv, req}), 16'h0006);
        do_reset();
        print_verdict();
    end
endmodule : mia_arbiter_tb_top
